/* File: design/clk_ctl.sv */
`timescale 1ns/10ps
`include "clk_ctl_cfg.svh"
// What this block does
// - external clock modes need no start-up wait
// - plain external mode outputs clock divided four
// - crystal mode: no clock/4, feedback stays on
// - external codes 111/101 quadruple source clock; 110 never does
// - external multiplier needs code 111/101 and enable
// - clearing multiplier enable disables multiplier everywhere
// - fast rc 8 MHz, postscaler 31k to 4M
// - fast rc on at 125k and up; 31k uses source bit
// - slow rc on when selected or features need
// - frequency field picks source; resets to 4 MHz
// - internal clkout mode: clock/4 out, in pin port
// - internal all-io mode: both pins are port
// - internal times-four gives 16 or 32 MHz
// - internal multiplier only with codes 011/001
// - internal multiplier only at 4 or 8 MHz
// - internal x4 modes share pin functions of internal
// - trim shifts fast rc within 1 ms, no status
// - slow rc independent of trim value
// - source field 10/01/11 picks clock, reset clears
// - switching pauses two old plus four new cycles
module clk_ctl
#(
	parameter int SETTLE_CYC = `TUNE_SETTLE_CYC
)
(
	input  wire logic                 clk_in,          // 40 MHz clock
	input  wire logic                 rst_in,          // sync reset
	input  wire clk_ctl_pkg::wb_req_s wb_in,           // wishbone request
	input  wire logic [2:0]           pri_cfg_in,      // fused mode
	input  wire logic                 feat_wdt_in,     // watchdog on
	input  wire logic                 feat_fscm_in,    // clock monitor on
	input  wire logic                 feat_pwrt_in,    // power-up timer
	input  wire logic                 feat_twospd_in,  // two-speed start
	output logic [31:0]               wb_dat_out,      // read data
	output logic                      wb_ack_out,      // ack
	output clk_ctl_pkg::pin_func_s    pin_func_out,    // pin roles
	output logic                      clk_out_pin_out, // clock-out value
	output logic                      clk_out_oe_out,  // clock-out enable
	output logic                      mult_on_out,     // multiplier on
	output logic                      fast_rc_on_out,  // fast rc enabled
	output logic                      slow_rc_on_out,  // slow rc enabled
	output logic [3:0]                post_div_out,    // postscale log2
	output logic                      use_fast_rc_out, // fast rc drives
	output logic [5:0]                rc_trim_out,     // applied trim
	output logic                      start_wait_out,  // start-up needed
	output logic [1:0]                active_src_out,  // source in use
	output logic                      clk_gate_out     // clock paused
);
	import clk_ctl_pkg::*;

	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		logic [1:0]  clock_source_select;    // source field
		logic [2:0]  rc_frequency_select;    // frequency field
		logic [5:0]  trim_value;             // tune field
		logic        multiplier_enable;      // x4 enable
		logic        low_freq_source_select; // 31k from fast rc
		logic [1:0]  active;                 // active source
		sw_state_e   sw;                     // switch sequencer
		logic [2:0]  sw_cnt;                 // pause counter
		logic        ack;                    // bus ack
		logic [31:0] rdat;                   // read data
		pin_func_s   pins;                   // pin roles
		logic        mult;                   // multiplier on
		logic        fast_on;                // fast rc on
		logic        slow_on;                // slow rc on
		logic [3:0]  post;                   // postscale
		logic        use_fast;               // fast rc selected
		logic        wait_st;                // start-up wait
		logic        gate;                   // clock held
		logic        clk4_run;               // divider run
	} state_s;

	state_s st;       // registered state
	state_s next_st;  // next state

	logic       tune_write;  // trim register written
	logic [5:0] trim_apply;  // trim after shift start
	logic       clk4;        // divider output

	// ********************************************************
	// helper functions
	// ********************************************************
	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// is the fused mode one of the internal ones or plain external
	function automatic logic is_internal(input logic [2:0] c);
		return (c == `PRI_INT_OUT) || (c == `PRI_EXT_PLAIN) ||
			(c == `PRI_INT_X4_OUT) || (c == `PRI_INT_X4_IO);
	endfunction

	// ********************************************************
	// next-state logic
	// ********************************************************
	always_comb
	begin
		logic        wr;
		logic        rd;
		logic [31:0] w;
		logic        ext_x4;
		logic        int_x4;
		logic        internal;
		logic [1:0]  want;
		wr = 1'b0;
		rd = 1'b0;
		w = 32'h0;
		ext_x4 = 1'b0;
		int_x4 = 1'b0;
		internal = 1'b0;
		want = `SRC_PRIMARY;
		next_st = st;
		tune_write = 1'b0;

		// bus: ack one cycle, drop it the cycle after
		wr = wb_in.cyc && wb_in.stb && wb_in.we && !st.ack;
		rd = wb_in.cyc && wb_in.stb && !wb_in.we && !st.ack;
		next_st.ack = wb_in.cyc && wb_in.stb && !st.ack;
		if (wr)
		begin
			case (wb_in.adr)
				`OFS_CLK_CTL:
				begin
					w = merge({25'h0, st.rc_frequency_select, 2'h0,
						st.clock_source_select}, wb_in.dat, wb_in.sel);
					next_st.rc_frequency_select = w[6:4];
					next_st.clock_source_select = w[1:0];
				end
				`OFS_TRIM:
				begin
					w = merge({24'h0, st.low_freq_source_select,
						st.multiplier_enable, st.trim_value},
						wb_in.dat, wb_in.sel);
					next_st.low_freq_source_select = w[`TRIM_LOWSRC_BIT];
					next_st.multiplier_enable = w[`TRIM_MULT_BIT];
					next_st.trim_value = w[5:0];
					tune_write = wb_in.sel[0];
				end
				default: ;
			endcase
		end
		if (rd)
		begin
			case (wb_in.adr)
				`OFS_CLK_CTL: next_st.rdat = {25'h0,
					st.rc_frequency_select, 2'h0, st.clock_source_select};
				`OFS_TRIM: next_st.rdat = {24'h0,
					st.low_freq_source_select, st.multiplier_enable,
					st.trim_value};
				`OFS_CFG: next_st.rdat = {29'h0, pri_cfg_in};
				`OFS_STATUS: next_st.rdat = {20'h0, st.post,
					st.use_fast, st.slow_on, st.fast_on, st.mult,
					st.active, st.gate, st.wait_st};
				default: next_st.rdat = 32'h0;
			endcase
		end

		internal = is_internal(pri_cfg_in);
		// external x4 needs its code and enable
		ext_x4 = st.multiplier_enable &&
			(pri_cfg_in == `PRI_EXT_CLK ||
			pri_cfg_in == `PRI_CRYSTAL_X4);
		// internal x4 needs its code, enable and 4/8 MHz
		int_x4 = st.multiplier_enable &&
			(pri_cfg_in == `PRI_INT_X4_OUT ||
			pri_cfg_in == `PRI_INT_X4_IO) &&
			(st.rc_frequency_select == `RCF_8MHZ ||
			st.rc_frequency_select == `RCF_4MHZ);
		next_st.mult = ext_x4 || int_x4;

		// fast rc: any setting but 31k, or 31k from fast rc
		next_st.fast_on = (st.rc_frequency_select != `RCF_31KHZ) ||
			st.low_freq_source_select;
		next_st.use_fast = next_st.fast_on;
		// postscale: 8 MHz direct, 31k 2^8, else 2^(7-code)
		next_st.post = (st.rc_frequency_select == `RCF_31KHZ) ?
			4'h8 : {1'b0, 3'h7 - st.rc_frequency_select};
		// slow rc: chosen as clock or any feature needs it
		next_st.slow_on = feat_wdt_in || feat_fscm_in || feat_pwrt_in
			|| feat_twospd_in || ((st.active == `SRC_INTERNAL ||
			internal) && st.rc_frequency_select == `RCF_31KHZ &&
			!st.low_freq_source_select);

		// pin roles by fused mode
		next_st.pins = '0;
		case (pri_cfg_in)
			`PRI_EXT_CLK, `PRI_EXT_PLAIN:
				next_st.pins.out_is_clk4 = 1'b1;
			`PRI_CRYSTAL, `PRI_CRYSTAL_X4, `PRI_EXT_CLK_X4B:
				next_st.pins.feedback_on = 1'b1;
			`PRI_INT_OUT, `PRI_INT_X4_OUT:
			begin
				next_st.pins.in_is_port  = 1'b1;
				next_st.pins.out_is_clk4 = 1'b1;
			end
			default:
			begin
				next_st.pins.in_is_port  = 1'b1;
				next_st.pins.out_is_port = 1'b1;
			end
		endcase
		next_st.clk4_run = next_st.pins.out_is_clk4;
		// only crystal modes wait for oscillator start
		next_st.wait_st = (pri_cfg_in == `PRI_CRYSTAL ||
			pri_cfg_in == `PRI_CRYSTAL_X4);

		// source switch with glitch-free pause
		want = (st.clock_source_select == `SRC_SECONDARY) ?
			`SRC_SECONDARY : (st.clock_source_select == `SRC_INTERNAL)
			? `SRC_INTERNAL : `SRC_PRIMARY;
		case (st.sw)
			sw_run:
				if (want != st.active)
				begin
					next_st.sw = sw_old;
					next_st.gate = 1'b1;
					next_st.sw_cnt = 3'(`SWITCH_OLD_CYC - 1);
				end
			sw_old:
				if (st.sw_cnt == 3'h0)
				begin
					next_st.sw = sw_new;
					next_st.active = want;
					next_st.sw_cnt = 3'(`SWITCH_NEW_CYC - 1);
				end
				else
					next_st.sw_cnt = st.sw_cnt - 3'h1;
			sw_new:
				if (st.sw_cnt == 3'h0)
				begin
					next_st.sw = sw_run;
					next_st.gate = 1'b0;
				end
				else
					next_st.sw_cnt = st.sw_cnt - 3'h1;
			default: next_st.sw = sw_run;
		endcase
	end

	// ********************************************************
	// state register
	// ********************************************************
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			st <= '0;
			st.rc_frequency_select <= `RCF_RESET;
			st.clock_source_select <= `SRC_RESET;
			st.active <= `SRC_PRIMARY;
			st.sw <= sw_run;
		end
		else
			st <= next_st;
	end

	// ********************************************************
	// sub-blocks
	// ********************************************************
	tune_settle #(.SETTLE_CYC(SETTLE_CYC)) u_tune
	(
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.start_in (tune_write),
		.trim_in  (next_st.trim_value),
		.trim_out (trim_apply),
		.busy_out ()
	);

	div4_gen u_div4
	(
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.run_in  (st.clk4_run),
		.div_out (clk4)
	);

	// ********************************************************
	// outputs, all from flip-flops
	// ********************************************************
	assign wb_dat_out      = st.rdat;
	assign wb_ack_out      = st.ack;
	assign pin_func_out    = st.pins;
	assign clk_out_pin_out = clk4;
	assign clk_out_oe_out  = st.clk4_run;
	assign mult_on_out     = st.mult;
	assign fast_rc_on_out  = st.fast_on;
	assign slow_rc_on_out  = st.slow_on;
	assign post_div_out    = st.post;
	assign use_fast_rc_out = st.use_fast;
	assign rc_trim_out     = trim_apply;
	assign start_wait_out  = st.wait_st;
	assign active_src_out  = st.active;
	assign clk_gate_out    = st.gate;

	// ********************************************************
	// checks
	// ********************************************************
	// outputs reflect the inputs sampled one edge earlier
	a_ext_mult_gate:
	assert property (@(posedge clk_in) disable iff (rst_in)
		!$past(rst_in) && mult_on_out && $past(pri_cfg_in[2]) |->
		$past(pri_cfg_in[0]) && $past(st.multiplier_enable))
		else $error("multiplier on in wrong external mode");
	a_mult_enable_off:
	assert property (@(posedge clk_in) disable iff (rst_in)
		$past(!st.multiplier_enable) && !$past(rst_in) |-> !mult_on_out)
		else $error("multiplier on while disabled");
	a_int_mult_freq:
	assert property (@(posedge clk_in) disable iff (rst_in)
		!$past(rst_in) && mult_on_out && !$past(pri_cfg_in[2]) |->
		$past(st.rc_frequency_select[2:1]) == 2'h3)
		else $error("internal multiplier at bad frequency");
	a_all_io_pins:
	assert property (@(posedge clk_in) disable iff (rst_in)
		$past(pri_cfg_in) == `PRI_INT_X4_IO && !$past(rst_in) |->
		pin_func_out.in_is_port && pin_func_out.out_is_port)
		else $error("all-io mode pins not released");
	a_crystal_no_clk4:
	assert property (@(posedge clk_in) disable iff (rst_in)
		$past(pri_cfg_in) == `PRI_CRYSTAL && !$past(rst_in) |->
		!clk_out_oe_out && pin_func_out.feedback_on)
		else $error("crystal mode drives clock-out");
	a_ext_no_wait:
	assert property (@(posedge clk_in) disable iff (rst_in)
		$past(pri_cfg_in) == `PRI_EXT_CLK && !$past(rst_in) |->
		!start_wait_out)
		else $error("start-up wait in external mode");
	a_switch_pause:
	assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(clk_gate_out) |-> clk_gate_out [*6] ##1 !clk_gate_out)
		else $error("switch pause not six cycles");
	a_fast_rc_on:
	assert property (@(posedge clk_in) disable iff (rst_in)
		$past(st.rc_frequency_select) != `RCF_31KHZ && !$past(rst_in)
		|-> fast_rc_on_out)
		else $error("fast rc off at high frequency");
	a_trim_apply:
	assert property (@(posedge clk_in) disable iff (rst_in)
		tune_write |=> rc_trim_out == $past(next_st.trim_value))
		else $error("trim not applied");
endmodule // clk_ctl

/* File: design/clk_ctl_cfg.svh */
`ifndef CLK_CTL_CFG_SVH
`define CLK_CTL_CFG_SVH

// register byte offsets on the wishbone slave
`define OFS_CLK_CTL      4'h0
`define OFS_TRIM         4'h4
`define OFS_CFG          4'h8
`define OFS_STATUS       4'hc

// primary configuration codes
`define PRI_EXT_CLK      3'h7
`define PRI_CRYSTAL_X4   3'h5
`define PRI_CRYSTAL      3'h4
`define PRI_EXT_CLK_X4B  3'h6
`define PRI_EXT_PLAIN    3'h2
`define PRI_INT_X4_OUT   3'h3
`define PRI_INT_X4_IO    3'h1
`define PRI_INT_OUT      3'h0

// internal frequency select codes
`define RCF_8MHZ         3'h7
`define RCF_4MHZ         3'h6
`define RCF_31KHZ        3'h0
`define RCF_RESET        3'h6

// clock source select codes
`define SRC_PRIMARY      2'h2
`define SRC_SECONDARY    2'h1
`define SRC_INTERNAL     2'h3
`define SRC_RESET        2'h0

// field positions
`define TRIM_MULT_BIT    6
`define TRIM_LOWSRC_BIT  7

// tune settle time and clock rate
`define TUNE_SETTLE_US   1000
`define CLK_MHZ          40
`define TUNE_SETTLE_CYC  (`TUNE_SETTLE_US * `CLK_MHZ)

// switch pause lengths in device clock cycles
`define SWITCH_OLD_CYC   2
`define SWITCH_NEW_CYC   4

`endif

/* File: design/clk_ctl_pkg.sv */
package clk_ctl_pkg;

	// wishbone request bundle
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

	// pin functions of the two oscillator pins
	typedef struct packed {
		logic in_is_port;   // clock-in pin is port a bit 7
		logic out_is_port;  // clock-out pin is port a bit 6
		logic out_is_clk4;  // clock-out pin drives clock / 4
		logic feedback_on;  // crystal feedback enabled
	} pin_func_s;

	// source-switch sequencer states
	typedef enum logic [1:0] {
		sw_run,
		sw_old,
		sw_new
	} sw_state_e;

endpackage

/* File: design/div4_gen.sv */
`timescale 1ns/10ps
// ********************************************************
// divide-by-four generator for the clock-out pin
// ********************************************************
module div4_gen
(
	input  wire logic clk_in,   // device clock
	input  wire logic rst_in,   // sync reset
	input  wire logic run_in,   // divider enabled
	output logic      div_out   // clock / 4 level
);
	import clk_ctl_pkg::*;

	// divider state
	typedef struct packed {
		logic [1:0] cnt;  // phase counter
		logic       lvl;  // clock / 4 level
	} div_s;

	div_s st;       // registered state
	div_s next_st;  // next state

	// count four phases, high for two of them
	always_comb
	begin
		next_st = st;
		if (!run_in)
			next_st = '0;
		else
		begin
			next_st.cnt = st.cnt + 2'h1;
			next_st.lvl = (st.cnt == 2'h1) || (st.cnt == 2'h2);
		end
	end

	// state register
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			st <= '0;
		else
			st <= next_st;
	end

	// registered output
	assign div_out = st.lvl;
endmodule // div4_gen

/* File: design/tune_settle.sv */
`timescale 1ns/10ps
`include "clk_ctl_cfg.svh"
// ********************************************************
// settle timer for fast rc retuning
// ********************************************************
module tune_settle
#(
	parameter int SETTLE_CYC = `TUNE_SETTLE_CYC
)
(
	input  wire logic       clk_in,     // device clock
	input  wire logic       rst_in,     // sync reset
	input  wire logic       start_in,   // new trim written
	input  wire logic [5:0] trim_in,    // requested trim
	output logic [5:0]      trim_out,   // trim applied to rc
	output logic            busy_out    // shift in progress
);
	import clk_ctl_pkg::*;

	// settle timer state
	typedef struct packed {
		logic [31:0] cnt;   // cycles left of the shift
		logic [5:0]  trim;  // trim applied to rc
		logic        busy;  // shift in progress
	} settle_s;

	settle_s st;       // registered state
	settle_s next_st;  // next state

	// apply trim at once, count settle window
	always_comb
	begin
		next_st = st;
		if (start_in)
		begin
			next_st.cnt  = 32'(SETTLE_CYC - 1);
			next_st.trim = trim_in;
			next_st.busy = 1'b1;
		end
		else if (st.cnt != 32'h0)
			next_st.cnt = st.cnt - 32'h1;
		else
			next_st.busy = 1'b0;
	end

	// state register
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			st <= '0;
		else
			st <= next_st;
	end

	// registered outputs
	assign trim_out = st.trim;
	assign busy_out = st.busy;
endmodule // tune_settle

/* File: dv/ext_src_model.sv */
`timescale 1ns/10ps
// ********************************************************
// far side: fused mode and feature levels for the block
// ********************************************************
module ext_src_model
(
	input  wire logic       clk_in,   // device clock
	input  wire logic [2:0] mode_in,  // fuse code wanted
	input  wire logic [3:0] feat_in,  // feature levels wanted
	output logic [2:0]      pri_out,  // fused mode seen by block
	output logic [3:0]      feat_out  // wdt, fscm, pwrt, twospd
);
	// levels move just after an edge, like a fuse reload
	always_ff @(posedge clk_in)
	begin
		pri_out  <= mode_in;
		feat_out <= feat_in;
	end
endmodule // ext_src_model

/* File: dv/oscillator_pll_fast_rc_oscillator_control_test.sv */
`timescale 1ns/10ps
`include "clk_ctl_cfg.svh"
module oscillator_pll_fast_rc_oscillator_control_test;
	import clk_ctl_pkg::*;
	// ********************************************************
	// signals and instances
	// ********************************************************
	localparam int SETTLE = 8;     // short settle count
	localparam int LIMIT  = 20000; // run ceiling in cycles
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	wb_req_s     wb     = '0;
	logic [2:0]  mode   = `PRI_EXT_CLK;
	logic [3:0]  feat   = 4'h0;
	logic [2:0]  pri;
	logic [3:0]  fl;
	logic [31:0] rdat, rd;
	logic        ack, cko, oe, mult, fast, slow, usef, stw, gate;
	pin_func_s   pins;
	logic [3:0]  post;
	logic [5:0]  trim;
	logic [1:0]  src;
	int          err_total   = 0;
	int          comparisons = 0;
	int          cycles      = 0;
	int          gate_cycles = 0; // cycles seen with the clock paused
	always #12.5 clk_in = ~clk_in;
	ext_src_model u_src (.clk_in(clk_in), .mode_in(mode), .feat_in(feat),
		.pri_out(pri), .feat_out(fl));
	clk_ctl #(.SETTLE_CYC(SETTLE)) DUT (.clk_in(clk_in), .rst_in(rst_in),
		.wb_in(wb), .pri_cfg_in(pri), .feat_wdt_in(fl[0]),
		.feat_fscm_in(fl[1]), .feat_pwrt_in(fl[2]), .feat_twospd_in(fl[3]),
		.wb_dat_out(rdat), .wb_ack_out(ack), .pin_func_out(pins),
		.clk_out_pin_out(cko), .clk_out_oe_out(oe), .mult_on_out(mult),
		.fast_rc_on_out(fast), .slow_rc_on_out(slow), .post_div_out(post),
		.use_fast_rc_out(usef), .rc_trim_out(trim), .start_wait_out(stw),
		.active_src_out(src), .clk_gate_out(gate));
	// ********************************************************
	// shared tasks
	// ********************************************************
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// classic cycle: hold until ack is sampled, then release
	task automatic wb_cyc(input logic we, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_in);
		wb <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:s, dat:d};
		do
		begin
			@(posedge clk_in);
		end
		while (ack !== 1'b1);
		rd = rdat;
		wb <= '0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		wb_cyc(1'b1, a, d, 4'hf);
	endtask
	task automatic set_mode(input logic [2:0] m);
		mode <= m;
		repeat (4) @(posedge clk_in);
	endtask
	// clock/4 on the clock-out pin: period 4, half period 2
	task automatic t_div(input string nm);
		logic [7:0] s;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_in);
			s[i] = cko;
		end
		check(nm, s[7:4], s[3:0]);
		check(nm, s[1:0] ^ s[3:2], 2'b11);
	endtask
	task automatic end_sim();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ********************************************************
	// scenarios
	// ********************************************************
	task automatic t_reset();
		wb_cyc(1'b0, `OFS_CLK_CTL, 32'h0, 4'hf);
		check("ctl reset", rd, 32'h60);
		check("src reset", src, `SRC_PRIMARY);
		check("post reset", post, 4'h1);
	endtask
	task automatic t_ext();
		set_mode(`PRI_EXT_CLK);
		check("ec pins", pins, 4'b0010);
		check("ec oe", oe, 1'b1);
		check("ec wait", stw, 1'b0);
		check("ec mult", mult, 1'b0);
		t_div("ec div");
		wr(`OFS_TRIM, 32'h40);
		check("ec x4", mult, 1'b1);
		set_mode(`PRI_CRYSTAL_X4);
		check("xt x4", mult, 1'b1);
		set_mode(`PRI_EXT_CLK_X4B);
		check("alt x4", mult, 1'b0);
		set_mode(`PRI_CRYSTAL);
		check("xt pins", pins, 4'b0001);
		check("xt wait", stw, 1'b1);
		check("xt mult", mult, 1'b0);
		set_mode(`PRI_CRYSTAL_X4);
		wr(`OFS_TRIM, 32'h0);
		check("x4 cleared", mult, 1'b0);
	endtask
	task automatic t_int();
		set_mode(`PRI_INT_OUT);
		check("int pins", pins, 4'b1010);
		t_div("int div");
		wr(`OFS_TRIM, 32'h40);
		check("int no x4", mult, 1'b0);
		set_mode(`PRI_INT_X4_OUT);
		check("x4 out pins", pins, 4'b1010);
		check("x4 4mhz", mult, 1'b1);
		set_mode(`PRI_INT_X4_IO);
		check("x4 io pins", pins, 4'b1100);
		wr(`OFS_CLK_CTL, 32'h70);
		check("x4 8mhz", mult, 1'b1);
		wr(`OFS_CLK_CTL, 32'h50);
		check("x4 2mhz", mult, 1'b0);
		wr(`OFS_TRIM, 32'h0);
	endtask
	task automatic t_freq();
		for (int c = 7; c >= 0; c--)
		begin
			wr(`OFS_CLK_CTL, 32'(c) << 4);
			check("postscale", post, c ? 4'(7 - c) : 4'h8);
			check("fast on", fast, c != 0);
			check("use fast", usef, c != 0);
			check("slow on", slow, c == 0);
		end
		wr(`OFS_TRIM, 32'h2a);
		check("slow trim", slow, 1'b1);
		check("slow post", post, 4'h8);
		wr(`OFS_TRIM, 32'h80);
		check("fast 31k", fast, 1'b1);
		wr(`OFS_CLK_CTL, 32'h70);
		for (int i = 0; i < 4; i++)
		begin
			feat <= 4'(1 << i);
			repeat (4) @(posedge clk_in);
			check("feature slow", slow, 1'b1);
		end
		feat <= 4'h0;
	endtask
	task automatic t_trim();
		int n;
		wr(`OFS_TRIM, 32'h15);
		n = 0;
		while (trim !== 6'h15 && n < SETTLE + 8)
		begin
			@(posedge clk_in);
			n++;
		end
		check("trim shift", trim, 6'h15);
		check("trim bound", n <= SETTLE + 2, 1'b1);
		wr(`OFS_TRIM, 32'h14);
		repeat (SETTLE + 4) @(posedge clk_in);
		check("trim lower", trim, 6'h14);
		wb_cyc(1'b1, `OFS_TRIM, 32'h3f, 4'h2);
		repeat (SETTLE + 4) @(posedge clk_in);
		check("trim lane", trim, 6'h14);
		wb_cyc(1'b0, 4'h2, 32'h0, 4'hf);
		check("unmapped", rd, 32'h0);
		wb_cyc(1'b0, `OFS_CFG, 32'h0, 4'hf);
		check("cfg read", rd, 32'(mode));
	endtask
	task automatic t_switch();
		int n;
		// count from before the write: the pause starts the cycle after its ack
		n = gate_cycles;
		wr(`OFS_CLK_CTL, 32'h63);
		repeat (12) @(posedge clk_in);
		check("pause len", gate_cycles - n, 6);
		check("src int", src, `SRC_INTERNAL);
		wb_cyc(1'b0, `OFS_STATUS, 32'h0, 4'hf);
		check("status", rd, 32'h1ac);
		wr(`OFS_CLK_CTL, 32'h61);
		repeat (12) @(posedge clk_in);
		check("src sec", src, `SRC_SECONDARY);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		t_reset();
	endtask
	// ********************************************************
	// main sequence and timeout
	// ********************************************************
	always @(posedge clk_in)
	begin
		cycles++;
		gate_cycles += (gate === 1'b1);
		if (cycles == LIMIT)
		begin
			err_total++;
			end_sim();
		end
	end
	initial
	begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		t_reset();
		t_ext();
		t_int();
		t_freq();
		t_trim();
		t_switch();
		end_sim();
	end
endmodule // oscillator_pll_fast_rc_oscillator_control_test
